// ===== hdl/asc_pkg.sv
// Shared constants and carrier types for the self-clocked serial result streamer.
// Assumes a 125 MHz system clock and a free-running internal serial-clock oscillator.
package asc_pkg;

  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned POR_TIME_US = 1000;
  localparam int unsigned POR_CYCLES = (CLK_HZ / 1_000_000) * POR_TIME_US;
  localparam int unsigned SAMP_INT_HZ = 123_000;
  localparam int unsigned SAMP_INT_CYCLES = CLK_HZ / SAMP_INT_HZ;
  localparam int unsigned SAMP_EXT_EDGES = 5;
  localparam int unsigned CONV_SAMPLES = 64;
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned RESULT_BITS = FRAME_BITS - 1;
  localparam int unsigned FIFO_DEPTH = 4;

  localparam logic EOC_BUSY = 1'h1;
  localparam logic EOC_DONE = 1'h0;
  localparam logic PIN_IDLE = 1'h1;

  typedef struct packed {
    logic eoc_n;
    logic [RESULT_BITS-1:0] result;
  } asc_frame_t;

  typedef struct packed {
    logic sck;
    logic sck_oe;
    logic sdo;
  } asc_pins_t;

  typedef enum logic [3:0] {
    LNK_CONV = 4'h1,
    LNK_SLEEP = 4'h2,
    LNK_HIGH = 4'h4,
    LNK_LOW = 4'h8
  } asc_link_state_t;

endpackage

// ===== hdl/asc_stream_out.sv
// Self-clocked continuous-conversion serial output: power-on mode capture,
// sampling strobe, conversion sequencing, result FIFO and the two-wire link.
// Assumes link_clk is the internal serial-clock oscillator, free running, and
// that the digital filter presents its result on filter_result in the mclk domain.
`timescale 1ns/1ns

module asc_fifo
  import asc_pkg::*;
#(
  parameter int unsigned WIDTH = FRAME_BITS,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  generate
    if (DEPTH < 2 || WIDTH < 1)
    begin : g_bad
      $error("asc_fifo needs DEPTH of at least 2 and a nonzero WIDTH");
    end
  endgenerate

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0] wr_ptr_ff;
  logic [PW-1:0] rd_ptr_ff;
  logic [CW-1:0] cnt_ff;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PTR_LAST) ? '0 : p + 1'h1;
  endfunction

  assign in_ready = (cnt_ff != CNT_FULL);
  assign out_valid = (cnt_ff != '0);
  assign out_data = mem_ff[rd_ptr_ff];

  always_ff @(posedge mclk)
  begin
    if (push)
      mem_ff[wr_ptr_ff] <= in_data;
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_ff <= ptr_step(wr_ptr_ff);
      if (pop)
        rd_ptr_ff <= ptr_step(rd_ptr_ff);
      if (push && !pop)
        cnt_ff <= cnt_ff + 1'h1;
      else if (pop && !push)
        cnt_ff <= cnt_ff - 1'h1;
    end
  end

endmodule

module asc_stream_out
  import asc_pkg::*;
#(
  parameter int unsigned POR_LEN = POR_CYCLES,
  parameter int unsigned SAMP_LEN = SAMP_INT_CYCLES,
  parameter int unsigned CONV_LEN = CONV_SAMPLES,
  parameter int unsigned DEPTH = FIFO_DEPTH
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  output logic sck_pullup_en,
  output logic sdo,
  input wire logic ext_clk_sel,
  input wire logic conversion_clock_pin,
  input wire logic [RESULT_BITS-1:0] filter_result,
  output logic samp_strobe,
  output logic conv_active,
  output logic por_done,
  output logic internal_mode
);

  generate
    if (POR_LEN < 2 || SAMP_LEN < 2 || CONV_LEN < 1)
    begin : g_bad
      $error("asc_stream_out counts must be at least 2, and CONV_LEN at least 1");
    end
  endgenerate

  localparam logic [31:0] POR_LAST = 32'(POR_LEN - 1);
  localparam logic [15:0] SAMP_LAST = 16'(SAMP_LEN - 1);
  localparam logic [15:0] CONV_LAST = 16'(CONV_LEN - 1);
  localparam logic [2:0] EXT_LAST = 3'(SAMP_EXT_EDGES - 1);
  localparam logic [4:0] FRAME_LAST = 5'(FRAME_BITS);

  // Power-on reset timer and clock-pin strap capture.
  logic [31:0] por_cnt_ff;
  logic por_done_ff;
  logic mode_int_ff;
  logic sck_s1_ff;
  logic sck_s2_ff;
  wire por_end = !por_done_ff && (por_cnt_ff == POR_LAST);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sck_s1_ff <= 1'h0;
      sck_s2_ff <= 1'h0;
    end
    else
    begin
      sck_s1_ff <= sck_i;
      sck_s2_ff <= sck_s1_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      por_cnt_ff <= '0;
      por_done_ff <= 1'h0;
      mode_int_ff <= 1'h0;
    end
    else if (por_end)
    begin
      por_done_ff <= 1'h1;
      mode_int_ff <= sck_s2_ff;
    end
    else if (!por_done_ff)
      por_cnt_ff <= por_cnt_ff + 32'h1;
  end

  // The pull-up only acts while the strap is being decided; after that the pin is ours or the host's.
  assign sck_pullup_en = ~por_done_ff;
  assign por_done = por_done_ff;
  assign internal_mode = mode_int_ff;
  wire run = por_done_ff & mode_int_ff;

  // Sampling strobe from either the internal divider or the external conversion clock.
  logic [15:0] samp_cnt_ff;
  logic cc_s1_ff;
  logic cc_s2_ff;
  logic cc_s3_ff;
  logic [2:0] ext_cnt_ff;
  logic strobe_ff;
  wire cc_edge = cc_s2_ff ^ cc_s3_ff;
  wire int_tick = (samp_cnt_ff == SAMP_LAST);
  wire ext_tick = cc_edge && (ext_cnt_ff == EXT_LAST);
  wire nxt_strobe = run & (ext_clk_sel ? ext_tick : int_tick);

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cc_s1_ff <= 1'h0;
      cc_s2_ff <= 1'h0;
      cc_s3_ff <= 1'h0;
    end
    else
    begin
      cc_s1_ff <= conversion_clock_pin;
      cc_s2_ff <= cc_s1_ff;
      cc_s3_ff <= cc_s2_ff;
    end
  end

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      samp_cnt_ff <= '0;
      ext_cnt_ff <= '0;
      strobe_ff <= 1'h0;
    end
    else
    begin
      samp_cnt_ff <= int_tick ? '0 : samp_cnt_ff + 16'h1;
      if (cc_edge)
        ext_cnt_ff <= (ext_cnt_ff == EXT_LAST) ? '0 : ext_cnt_ff + 3'h1;
      strobe_ff <= nxt_strobe;
    end
  end

  assign samp_strobe = strobe_ff;

  // Conversion sequencing; a new conversion waits for a free FIFO slot.
  logic conv_busy_ff;
  logic [15:0] conv_cnt_ff;
  logic fifo_in_ready;
  logic fifo_out_valid;
  asc_frame_t fifo_out_data;
  wire conv_done = conv_busy_ff && strobe_ff && (conv_cnt_ff == CONV_LAST);
  wire conv_start = run && !conv_busy_ff && fifo_in_ready;
  asc_frame_t conv_word;

  assign conv_word.eoc_n = EOC_DONE;
  assign conv_word.result = filter_result;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      conv_busy_ff <= 1'h0;
      conv_cnt_ff <= '0;
    end
    else if (conv_start)
    begin
      conv_busy_ff <= 1'h1;
      conv_cnt_ff <= '0;
    end
    else if (conv_done)
      conv_busy_ff <= 1'h0;
    else if (conv_busy_ff && strobe_ff)
      conv_cnt_ff <= conv_cnt_ff + 16'h1;
  end

  assign conv_active = conv_busy_ff;

  // Toggle handshake carries one held frame word into the link domain.
  logic req_ff;
  logic ack_s1_ff;
  logic ack_s2_ff;
  logic lnk_ack_ff;
  asc_frame_t xfer_ff;
  wire idle_xfer = (req_ff == ack_s2_ff);
  wire fifo_pop = fifo_out_valid & idle_xfer;

  asc_fifo #(.WIDTH(FRAME_BITS), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(conv_done),
    .in_ready(fifo_in_ready),
    .in_data(conv_word),
    .out_valid(fifo_out_valid),
    .out_ready(idle_xfer),
    .out_data(fifo_out_data)
  );

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ack_s1_ff <= 1'h0;
      ack_s2_ff <= 1'h0;
      req_ff <= 1'h0;
      xfer_ff <= '0;
    end
    else
    begin
      ack_s1_ff <= lnk_ack_ff;
      ack_s2_ff <= ack_s1_ff;
      if (fifo_pop)
      begin
        xfer_ff <= fifo_out_data;
        req_ff <= ~req_ff;
      end
    end
  end

  // Link domain: the oscillator clock; one link_clk cycle is half a serial-clock period.
  logic req_s1_ff;
  logic req_s2_ff;
  logic mode_s1_ff;
  logic mode_s2_ff;
  asc_link_state_t st_ff;
  asc_link_state_t nxt_st;
  asc_pins_t pins_ff;
  asc_pins_t nxt_pins;
  logic [RESULT_BITS-1:0] shift_ff;
  logic [RESULT_BITS-1:0] nxt_shift;
  logic [4:0] edge_cnt_ff;
  logic [4:0] nxt_edge_cnt;
  logic nxt_ack;
  wire lnk_start = (req_s2_ff != lnk_ack_ff) && mode_s2_ff;

  always_comb
  begin
    nxt_st = st_ff;
    nxt_pins = pins_ff;
    nxt_pins.sck_oe = mode_s2_ff;
    nxt_shift = shift_ff;
    nxt_edge_cnt = edge_cnt_ff;
    nxt_ack = lnk_ack_ff;
    case (st_ff)
      LNK_CONV:
      begin
        nxt_pins.sck = PIN_IDLE;
        nxt_pins.sdo = EOC_BUSY;
        if (lnk_start)
        begin
          nxt_pins.sck = 1'h0;
          nxt_pins.sdo = xfer_ff.eoc_n;
          nxt_shift = xfer_ff.result;
          nxt_st = LNK_SLEEP;
        end
      end
      LNK_SLEEP:
      begin
        nxt_pins.sck = 1'h1;
        nxt_edge_cnt = 5'h1;
        nxt_st = LNK_HIGH;
      end
      LNK_HIGH:
      begin
        if (edge_cnt_ff == FRAME_LAST)
        begin
          nxt_pins.sdo = EOC_BUSY;
          nxt_ack = req_s2_ff;
          nxt_st = LNK_CONV;
        end
        else
        begin
          nxt_pins.sck = 1'h0;
          nxt_pins.sdo = shift_ff[RESULT_BITS-1];
          nxt_shift = {shift_ff[RESULT_BITS-2:0], 1'h0};
          nxt_st = LNK_LOW;
        end
      end
      LNK_LOW:
      begin
        nxt_pins.sck = 1'h1;
        nxt_edge_cnt = edge_cnt_ff + 5'h1;
        nxt_st = LNK_HIGH;
      end
      default:
      begin
        nxt_pins.sck = PIN_IDLE;
        nxt_pins.sdo = EOC_BUSY;
        nxt_st = LNK_CONV;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      req_s1_ff <= 1'h0;
      req_s2_ff <= 1'h0;
      mode_s1_ff <= 1'h0;
      mode_s2_ff <= 1'h0;
    end
    else
    begin
      req_s1_ff <= req_ff;
      req_s2_ff <= req_s1_ff;
      mode_s1_ff <= run;
      mode_s2_ff <= mode_s1_ff;
    end
  end

  always_ff @(posedge link_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_ff <= LNK_CONV;
      pins_ff <= '{sck: PIN_IDLE, sck_oe: 1'h0, sdo: EOC_BUSY};
      shift_ff <= '0;
      edge_cnt_ff <= '0;
      lnk_ack_ff <= 1'h0;
    end
    else
    begin
      st_ff <= nxt_st;
      pins_ff <= nxt_pins;
      shift_ff <= nxt_shift;
      edge_cnt_ff <= nxt_edge_cnt;
      lnk_ack_ff <= nxt_ack;
    end
  end

  // The receiver may hold chip select low for good, so the data pin is always driven.
  assign sck_o = pins_ff.sck;
  assign sck_oe = pins_ff.sck_oe;
  assign sdo = pins_ff.sdo;

endmodule

// ===== bench/asc_stream_monitor.sv
// Checker for the self-clocked result streamer, bound to its top module.
// Assumes arst_n resets both domains and link_clk runs free.
`timescale 1ns/1ns
module asc_stream_monitor
  import asc_pkg::*;
#(
  parameter int unsigned POR_LEN = 20,
  parameter int unsigned SAMP_LEN = 4
)
(
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic link_clk,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic sck_pullup_en,
  input wire logic sdo,
  input wire logic ext_clk_sel,
  input wire logic samp_strobe,
  input wire logic conv_active,
  input wire logic por_done,
  input wire logic internal_mode
);
  logic [31:0] por_cnt_ff;
  logic [31:0] gap_ff;
  logic seen_ff;

  always_ff @(posedge mclk or negedge arst_n)
    if (!arst_n)
    begin
      por_cnt_ff <= 32'h0;
      gap_ff <= 32'h0;
      seen_ff <= 1'h0;
    end
    else
    begin
      por_cnt_ff <= por_done ? por_cnt_ff : por_cnt_ff + 32'h1;
      gap_ff <= samp_strobe ? 32'h0 : gap_ff + 32'h1;
      seen_ff <= seen_ff | samp_strobe;
    end

  // Only the opening fall follows a long high; the fall of a zero data bit had sck low two cycles before.
  sequence frm_start;
    $fell(sck_o) && $past(sck_o, 2) && !sdo && sck_oe;
  endsequence

  chk_por_length: assert property (@(posedge mclk) disable iff (!arst_n)
    por_done |-> por_cnt_ff == POR_LEN) else $error("power-on interval wrong");
  chk_mode_frozen: assert property (@(posedge mclk) disable iff (!arst_n)
    $past(por_done) |-> $stable(internal_mode)) else $error("mode changed after reset end");
  chk_pullup_por: assert property (@(posedge mclk) disable iff (!arst_n)
    sck_pullup_en == !por_done) else $error("pull-up not tied to power-on phase");
  chk_samp_period: assert property (@(posedge mclk) disable iff (!arst_n)
    samp_strobe && seen_ff && !ext_clk_sel |-> gap_ff == SAMP_LEN - 1) else $error("strobe spacing wrong");
  chk_conv_gated: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_active || samp_strobe |-> por_done && internal_mode) else $error("activity outside self-clocked mode");
  chk_idle_high: assert property (@(posedge link_clk) disable iff (!arst_n)
    !sck_oe |-> sck_o && sdo) else $error("idle pins not high");
  chk_oe_mode: assert property (@(posedge link_clk) disable iff (!arst_n)
    sck_oe |-> internal_mode && por_done) else $error("clock driven in wrong mode");
  chk_sleep_half: assert property (@(posedge link_clk) disable iff (!arst_n)
    frm_start |=> sck_o && !sdo) else $error("sleep length or status bit wrong");
  chk_frame_end: assert property (@(posedge link_clk) disable iff (!arst_n)
    frm_start |-> ##46 !sck_o ##1 sck_o ##1 (sck_o && sdo)) else $error("frame length wrong");
  chk_data_fall: assert property (@(posedge link_clk) disable iff (!arst_n)
    $changed(sdo) && sck_oe |-> $fell(sck_o) || $past(sck_o)) else $error("data moved off falling edge");

  cover property (@(posedge link_clk) disable iff (!arst_n) frm_start);
  cover property (@(posedge mclk) disable iff (!arst_n) $rose(conv_active));
  cover property (@(posedge mclk) disable iff (!arst_n) samp_strobe && ext_clk_sel);
endmodule

bind asc_stream_out asc_stream_monitor #(.POR_LEN(POR_LEN), .SAMP_LEN(SAMP_LEN)) u_mon (.mclk(mclk),
  .arst_n(arst_n), .link_clk(link_clk), .sck_o(sck_o), .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en),
  .sdo(sdo), .ext_clk_sel(ext_clk_sel), .samp_strobe(samp_strobe), .conv_active(conv_active),
  .por_done(por_done), .internal_mode(internal_mode));

// ===== bench/asc_rx_model.sv
// Receiver on the far side of the two-wire output link.
// Assumes the clock pin level is already resolved by the bench.
`timescale 1ns/1ns
module asc_rx_model
  import asc_pkg::*;
(
  input wire logic arst_n,
  input wire logic sck_pin,
  input wire logic sdo,
  output logic [FRAME_BITS-1:0] word,
  output logic [15:0] frames
);
  logic [FRAME_BITS-1:0] sh;
  logic [4:0] n;

  // No chip select exists here: the receiver behaves as if it were held low.
  always @(posedge sck_pin or negedge arst_n)
    if (!arst_n)
    begin
      n = 5'h0;
      frames = 16'h0;
      word = '0;
    end
    else
    begin
      sh = {sh[FRAME_BITS-2:0], sdo};
      n = n + 5'h1;
      if (n == 5'd24)
      begin
        word = sh;
        frames = frames + 16'h1;
        n = 5'h0;
      end
    end
endmodule

// ===== bench/asc_stream_out_bench.sv
// Self-checking bench for the self-clocked result streamer.
// Assumes a bench pull-up on the clock pin when nobody drives it, except while strap_lo holds the pin low.
`timescale 1ns/1ns
module asc_stream_out_bench;
  import asc_pkg::*;
  localparam int unsigned PL = 20;
  logic mclk;
  logic link_clk;
  logic arst_n;
  logic ext_clk_sel;
  logic cclk;
  logic strap_lo;
  logic [RESULT_BITS-1:0] fres;
  logic sck_o;
  logic sck_oe;
  logic sdo;
  logic samp_strobe;
  logic conv_active;
  logic por_done;
  logic internal_mode;
  logic [FRAME_BITS-1:0] word;
  logic [15:0] frames;
  int num_errors;
  int checks_done;
  wire sck_pin = sck_oe ? sck_o : !strap_lo;

  asc_stream_out #(.POR_LEN(PL), .SAMP_LEN(4), .CONV_LEN(2)) uut (.mclk(mclk), .arst_n(arst_n),
    .link_clk(link_clk), .sck_i(sck_pin), .sck_o(sck_o), .sck_oe(sck_oe), .sck_pullup_en(), .sdo(sdo),
    .ext_clk_sel(ext_clk_sel), .conversion_clock_pin(cclk), .filter_result(fres),
    .samp_strobe(samp_strobe), .conv_active(conv_active), .por_done(por_done), .internal_mode(internal_mode));
  asc_rx_model u_rx (.arst_n(arst_n), .sck_pin(sck_pin), .sdo(sdo), .word(word), .frames(frames));

  always #4 mclk = ~mclk;
  // The conversion clock is offset so its edges never meet a system clock edge.
  initial
  begin
    cclk = 0;
    #1;
    forever #20 cclk = ~cclk;
  end
  // Offset start keeps the link edges away from the system clock edges.
  initial
  begin
    link_clk = 0;
    #3;
    forever #80 link_clk = ~link_clk;
  end

  task automatic end_sim();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Reset is held long enough for two link edges so both domains clear.
  task automatic do_reset(input logic ext, input logic lo, input logic [22:0] val);
    int n;
    @(posedge mclk);
    #1;
    arst_n = 0;
    ext_clk_sel = ext;
    strap_lo = lo;
    fres = val;
    repeat (20) @(posedge mclk);
    #1;
    arst_n = 1;
    n = 0;
    while (por_done !== 1'b1 && n < 200)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    check("por_len", PL, n);
    if (n == 200)
    begin
      num_errors++;
      end_sim();
    end
    check("mode", !lo, internal_mode);
  endtask

  task automatic run_mode(input logic ext, input logic [22:0] val, input int lo, input int hi);
    int n;
    int s;
    logic [15:0] f0;
    do_reset(ext, 0, val);
    s = 0;
    repeat (1000)
    begin
      @(posedge mclk);
      #1;
      s += samp_strobe;
    end
    check("strobes", 1, s >= lo && s <= hi);
    for (int k = 0; k < 3; k++)
    begin
      f0 = frames;
      n = 0;
      while (frames == f0 && n < 4000)
      begin
        @(posedge mclk);
        n++;
      end
      if (n == 4000)
      begin
        num_errors++;
        end_sim();
      end
      check("frame", {EOC_DONE, val}, word);
    end
  endtask

  task automatic strap_low_test();
    int seen;
    logic [15:0] f0;
    do_reset(0, 1, 23'h1);
    f0 = frames;
    seen = 0;
    repeat (2000)
    begin
      @(posedge mclk);
      seen += sck_oe | conv_active | !sdo;
    end
    check("ext_quiet", 0, seen);
    check("ext_frames", f0, frames);
  endtask

  initial
  begin
    mclk = 0;
    arst_n = 0;
    ext_clk_sel = 0;
    strap_lo = 0;
    fres = '0;
    num_errors = 0;
    checks_done = 0;
    run_mode(0, 23'h5a3c96, 249, 251);
    run_mode(1, 23'h2b4d3a, 79, 81);
    strap_low_test();
    end_sim();
  end
endmodule
